// File: ext_seq_pkg.sv
// Constants and types shared by the extension unlock and aperture logic.
package ext_seq_pkg;

   // Sequencer data-port indices of the two extension registers.
   localparam logic [7:0] IDX_UNLOCK_KEY = 8'h06;
   localparam logic [7:0] IDX_EXT_SEQ_MODE = 8'h07;

   // Unlock key: mask and value of the significant bits, readback patterns.
   localparam logic [7:0] KEY_MASK = 8'h17;
   localparam logic [7:0] KEY_VALUE = 8'h12;
   localparam logic [7:0] KEY_READ_OPEN = 8'h12;
   localparam logic [7:0] KEY_READ_LOCKED = 8'h0f;

   // Extended sequencer mode field layout and reset value.
   localparam int SEG_LSB = 4;
   localparam int SEG_W = 4;
   localparam int DIV_LSB = 1;
   localparam int DIV_W = 3;
   localparam int HIRES_BIT = 0;
   localparam logic [7:0] EXT_SEQ_MODE_RST = 8'h00;
   localparam logic [3:0] SEG_LEGACY = 4'h0;

   // Host bus kinds.
   typedef enum logic [1:0] {
      BUS_ISA = 2'b00,
      BUS_LOCAL = 2'b01,
      BUS_PCI = 2'b10
   } bus_kind_t;

   // Aperture layouts inside the PCI range.
   typedef enum logic [1:0] {
      PCI_LOW_4MB = 2'b00,
      PCI_LOW_2MB = 2'b01,
      PCI_FOUR_SWAP = 2'b10
   } pci_layout_t;

   // Character clock divider modes.
   typedef enum logic [2:0] {
      DIV_NORMAL = 3'b000,
      DIV_BY2_16BPP = 3'b001,
      DIV_BY3_24BPP = 3'b010,
      DIV_16BPP_PIX = 3'b011,
      DIV_32BPP_PIX = 3'b100
   } div_mode_t;

   // Pixels (dot enables) per character clock.
   localparam logic [4:0] DOTS_NARROW = 5'h08;
   localparam logic [4:0] DOTS_WIDE = 5'h09;
   localparam logic [4:0] DOTS_BY2 = 5'h10;
   localparam logic [4:0] DOTS_BY3 = 5'h18;

   // Legacy memory map select values and window bounds (20-bit space).
   localparam logic [1:0] MAP_A_B = 2'b00;
   localparam logic [1:0] MAP_A64 = 2'b01;
   localparam logic [1:0] MAP_B0 = 2'b10;
   localparam logic [19:0] WIN_A_LO = 20'ha0000;
   localparam logic [19:0] WIN_A_HI = 20'hb0000;
   localparam logic [19:0] WIN_B8_LO = 20'hb8000;
   localparam logic [19:0] WIN_B_END = 20'hc0000;

endpackage : ext_seq_pkg

// File: pin_sync.sv
// Two-flop synchroniser for levels arriving from pins.
module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stage_r <= '0;
         sync_out <= '0;
      end else begin
         stage_r <= async_in;
         sync_out <= stage_r;
      end
   end

endmodule : pin_sync

// File: extension_unlock_aperture_decode.sv
// Extension unlock key, extended sequencer mode and aperture decode.
// Notes on behaviour
// RULE1: Key pattern xxx1x010 unlocks, reads 00010010.
// RULE2: Any other key value reads 00001111.
// RULE3: Locked blocks extension reads and writes.
// RULE4: Segment field zero gives legacy A/B decode.
// RULE5: ISA claims when address 23:20 equals field.
// RULE6: ISA two-megabyte bit ignores field bit zero.
// RULE7: Local bus claims when both decode inputs high.
// RULE8: PCI aperture start from base address register.
// RULE9: PCI window lowest 4/2 MB, or swap apertures.
// RULE10: One-to-one 4 MB only chain-4, else 1 MB wrap.
// RULE11: Mode bits 3:1 select character clock divider.
// RULE12: Divider codes 000..100 decoded, rest reserved.
// RULE13: Bit 0 gives eight-pixel characters, packed addressing.
// RULE14: Reset leaves extension registers locked; with ALWAYS_UNLOCKED set they are open from reset.
module extension_unlock_aperture_decode
   import ext_seq_pkg::*;
#(
   parameter ext_seq_pkg::bus_kind_t BUS = ext_seq_pkg::BUS_ISA,
   parameter ext_seq_pkg::pci_layout_t PCI_LAYOUT = ext_seq_pkg::PCI_LOW_4MB,
   parameter bit ALWAYS_UNLOCKED = 1'b0
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // Sequencer indexed data port
   input wire logic [7:0] SEQ_INDEX,
   input wire logic SEQ_WR,
   input wire logic SEQ_RD,
   input wire logic [7:0] SEQ_WDATA,
   output logic [7:0] SEQ_RDATA,
   output logic SEQ_RHIT,
   // Host memory cycle
   input wire logic MEM_REQ,
   input wire logic [31:0] MEM_ADDR,
   input wire logic HIGH_MEMORY_DECODE_INPUT,
   input wire logic LOW_MEMORY_DECODE_INPUT,
   input wire logic [7:0] PCI_BASE,
   // Settings held elsewhere in the controller
   input wire logic [1:0] LEGACY_MAP_SEL,
   input wire logic TWO_MEGABYTE_WINDOW_BIT,
   input wire logic CHAIN4_256,
   input wire logic NINE_DOT_CHARS,
   // Display timing
   input wire logic DOT_CLK_EN,
   output logic CHAR_CLK_EN,
   // Decode results
   output logic MEM_CLAIM,
   output logic [21:0] MEM_OFFSET,
   output logic [1:0] SWAP_APERTURE,
   output logic EXT_UNLOCKED,
   output logic [2:0] CHAR_CLOCK_DIVIDER_FIELD,
   output logic HIGH_RES_PACKED
);

   import ext_seq_pkg::*;

   // Refuse a bus kind that the decode below has no branch for.
   if (BUS != BUS_ISA && BUS != BUS_LOCAL &&
       BUS != BUS_PCI) begin : g_bad_bus
      $error("Unsupported host bus kind.");
   end

   // Legacy window hit for the low megabyte, per map select.
   function automatic logic legacy_hit(input logic [1:0] sel,
                                       input logic [19:0] a);
      logic hit;
      hit = 1'b0;
      case (sel)
         MAP_A_B: hit = (a >= WIN_A_LO) && (a < WIN_B_END);
         MAP_A64: hit = (a >= WIN_A_LO) && (a < WIN_A_HI);
         MAP_B0: hit = (a >= WIN_A_HI) && (a < WIN_B8_LO);
         default: hit = (a >= WIN_B8_LO) && (a < WIN_B_END);
      endcase
      return hit;
   endfunction : legacy_hit

   // Pixels per character for the selected divider mode.
   function automatic logic [4:0] dots_per_char(input logic [2:0] mode,
                                                input logic hires,
                                                input logic nine);
      logic [4:0] n;
      n = DOTS_NARROW;
      case (mode)
         DIV_NORMAL: n = (nine && !hires) ? DOTS_WIDE : DOTS_NARROW;
         DIV_BY2_16BPP: n = DOTS_BY2;
         DIV_BY3_24BPP: n = DOTS_BY3;
         DIV_16BPP_PIX: n = DOTS_NARROW;
         DIV_32BPP_PIX: n = DOTS_NARROW;
         default: n = DOTS_NARROW;
      endcase
      return n;
   endfunction : dots_per_char

   logic key_open_r;
   logic [7:0] mode_r;
   logic unlocked;
   logic high_memory_decode_input_s;
   logic low_memory_decode_input_s;
   logic [3:0] seg;
   logic [2:0] div_sel;
   logic claim_nxt;
   logic [21:0] offset_nxt;
   logic [1:0] swap_nxt;
   logic [4:0] dot_cnt_r;
   logic [4:0] dot_limit;

   // Decode strobes come from pins and cross into this clock first.
   pin_sync #(
      .WIDTH(2)
   ) u_decode_sync (
      .clk(CLK),
      .nrst(NRST),
      .async_in({HIGH_MEMORY_DECODE_INPUT, LOW_MEMORY_DECODE_INPUT}),
      .sync_out({high_memory_decode_input_s, low_memory_decode_input_s})
   );

   assign unlocked = key_open_r || ALWAYS_UNLOCKED; // see RULE3
   assign seg = mode_r[SEG_LSB +: SEG_W];
   assign div_sel = mode_r[DIV_LSB +: DIV_W]; // see RULE11

   // Unlock key; only whether the significant bits match is remembered.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         key_open_r <= 1'b0; // see RULE14
      end else if (SEQ_WR && SEQ_INDEX == IDX_UNLOCK_KEY) begin
         key_open_r <= (SEQ_WDATA & KEY_MASK) == KEY_VALUE; // see RULE1
      end
   end

   // Extended sequencer mode register, writable only while unlocked.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         mode_r <= EXT_SEQ_MODE_RST;
      end else if (SEQ_WR && SEQ_INDEX == IDX_EXT_SEQ_MODE && unlocked) begin
         mode_r <= SEQ_WDATA; // see RULE3
      end
   end

   // Read port; a blocked read is not claimed and returns zero.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         SEQ_RDATA <= 8'h00;
         SEQ_RHIT <= 1'b0;
      end else if (SEQ_RD && SEQ_INDEX == IDX_UNLOCK_KEY) begin
         // The readback follows the last key written, even when the
         // variant keeps the extensions permanently open.
         SEQ_RDATA <= key_open_r ? KEY_READ_OPEN : KEY_READ_LOCKED; // see RULE2
         SEQ_RHIT <= 1'b1;
      end else if (SEQ_RD && SEQ_INDEX == IDX_EXT_SEQ_MODE && unlocked) begin
         SEQ_RDATA <= mode_r; // see RULE3
         SEQ_RHIT <= 1'b1;
      end else begin
         SEQ_RDATA <= 8'h00;
         SEQ_RHIT <= 1'b0;
      end
   end

   // Aperture decode for one host memory cycle.
   always_comb begin
      claim_nxt = 1'b0;
      swap_nxt = 2'b00;
      offset_nxt = {2'b00, MEM_ADDR[19:0]};
      if (seg == SEG_LEGACY) begin
         claim_nxt = (MEM_ADDR[31:20] == 12'h000) &&
                     legacy_hit(LEGACY_MAP_SEL, MEM_ADDR[19:0]); // see RULE4
      end else begin
         case (BUS)
            BUS_ISA: begin
               if (TWO_MEGABYTE_WINDOW_BIT) begin
                  claim_nxt = MEM_ADDR[23:21] == seg[3:1]; // see RULE6
                  offset_nxt = {1'b0, MEM_ADDR[20:0]};
               end else begin
                  claim_nxt = MEM_ADDR[23:20] == seg; // see RULE5
               end
            end
            BUS_LOCAL: begin
               claim_nxt = high_memory_decode_input_s && low_memory_decode_input_s; // see RULE7
               offset_nxt = MEM_ADDR[21:0];
            end
            BUS_PCI: begin
               offset_nxt = MEM_ADDR[21:0];
               case (PCI_LAYOUT) // see RULE9
                  PCI_LOW_4MB:
                     claim_nxt = (MEM_ADDR[31:24] == PCI_BASE) &&
                                 (MEM_ADDR[23:22] == 2'b00); // see RULE8
                  PCI_LOW_2MB: begin
                     claim_nxt = (MEM_ADDR[31:24] == PCI_BASE) &&
                                 (MEM_ADDR[23:21] == 3'b000);
                     offset_nxt = {1'b0, MEM_ADDR[20:0]};
                  end
                  default: begin
                     claim_nxt = MEM_ADDR[31:24] == PCI_BASE;
                     swap_nxt = MEM_ADDR[23:22];
                  end
               endcase
            end
            default: claim_nxt = 1'b0;
         endcase
         // Without chain-4 the linear range folds onto one megabyte.
         if (!CHAIN4_256) begin
            offset_nxt = {2'b00, offset_nxt[19:0]}; // see RULE10
         end
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         MEM_CLAIM <= 1'b0;
         MEM_OFFSET <= '0;
         SWAP_APERTURE <= 2'b00;
      end else begin
         MEM_CLAIM <= MEM_REQ && claim_nxt;
         MEM_OFFSET <= offset_nxt;
         SWAP_APERTURE <= swap_nxt;
      end
   end

   // Character clock: one enable every N dot enables.
   assign dot_limit = dots_per_char(div_sel, mode_r[HIRES_BIT],
                                    NINE_DOT_CHARS); // see RULE12 RULE13

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         dot_cnt_r <= 5'h00;
         CHAR_CLK_EN <= 1'b0;
      end else begin
         CHAR_CLK_EN <= 1'b0;
         if (DOT_CLK_EN) begin
            // Reprogramming a shorter limit mid-character ends it at the next dot enable.
            if (dot_cnt_r + 5'h01 >= dot_limit) begin
               dot_cnt_r <= 5'h00;
               CHAR_CLK_EN <= 1'b1; // see RULE11
            end else begin
               dot_cnt_r <= dot_cnt_r + 5'h01;
            end
         end
      end
   end

   // Status mirrors.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         EXT_UNLOCKED <= 1'b0;
         CHAR_CLOCK_DIVIDER_FIELD <= 3'b000;
         HIGH_RES_PACKED <= 1'b0;
      end else begin
         EXT_UNLOCKED <= unlocked;
         CHAR_CLOCK_DIVIDER_FIELD <= div_sel;
         HIGH_RES_PACKED <= mode_r[HIRES_BIT]; // see RULE13
      end
   end

endmodule : extension_unlock_aperture_decode

// File: eu_assertions.sv
// Port-level checks of the unlock key, mode register and decode timing.
module eu_checker (
   // Clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // Sequencer port
   input wire logic [7:0] SEQ_INDEX,
   input wire logic SEQ_WR,
   input wire logic SEQ_RD,
   input wire logic [7:0] SEQ_WDATA,
   input wire logic [7:0] SEQ_RDATA,
   input wire logic SEQ_RHIT,
   input wire logic EXT_UNLOCKED,
   input wire logic [2:0] CHAR_CLOCK_DIVIDER_FIELD,
   // Decode and timing
   input wire logic MEM_REQ,
   input wire logic [31:0] MEM_ADDR,
   input wire logic MEM_CLAIM,
   input wire logic [21:0] MEM_OFFSET,
   input wire logic CHAIN4_256,
   input wire logic DOT_CLK_EN,
   input wire logic CHAR_CLK_EN
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   // The decode checks hold for the ISA variant except with segment 1 and the two-megabyte bit set.
   sequence s_key_rd;
      SEQ_RD && SEQ_INDEX == 8'h06;
   endsequence
   sequence s_mode_wr;
      SEQ_WR && SEQ_INDEX == 8'h07 && !$past(SEQ_WR);
   endsequence
   property p_key_rd;
      s_key_rd |=> SEQ_RHIT && SEQ_RDATA == (EXT_UNLOCKED ? 8'h12 : 8'h0f);
   endproperty
   a_key_rd: assert property (p_key_rd) else $error("key readback wrong");
   property p_mode_rd;
      SEQ_RD && SEQ_INDEX == 8'h07 |=>
         SEQ_RHIT == EXT_UNLOCKED && (EXT_UNLOCKED || SEQ_RDATA == 8'h00);
   endproperty
   a_mode_rd: assert property (p_mode_rd) else $error("locked read served");
   property p_mode_wr;
      s_mode_wr and EXT_UNLOCKED |=> ##1
         CHAR_CLOCK_DIVIDER_FIELD == $past(SEQ_WDATA[3:1], 2);
   endproperty
   a_mode_wr: assert property (p_mode_wr) else $error("field not written");
   property p_locked_wr;
      s_mode_wr and !EXT_UNLOCKED |=> $stable(CHAR_CLOCK_DIVIDER_FIELD) [*2];
   endproperty
   a_locked_wr: assert property (p_locked_wr) else $error("locked write");
   property p_rd_idle;
      !SEQ_RD |=> SEQ_RDATA == 8'h00 && !SEQ_RHIT;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data stays");
   property p_no_req;
      !MEM_REQ |=> !MEM_CLAIM;
   endproperty
   a_no_req: assert property (p_no_req) else $error("claim without req");
   property p_low_mem;
      MEM_REQ && MEM_ADDR[31:20] == 12'h000 && MEM_ADDR[19:17] != 3'b101
         |=> !MEM_CLAIM;
   endproperty
   a_low_mem: assert property (p_low_mem) else $error("claim outside A/B");
   property p_offset;
      MEM_CLAIM && !$past(CHAIN4_256) |-> MEM_OFFSET[21:20] == 2'b00;
   endproperty
   a_offset: assert property (p_offset) else $error("offset no wrap");
   property p_char;
      CHAR_CLK_EN |-> $past(DOT_CLK_EN) ##1 !CHAR_CLK_EN;
   endproperty
   a_char: assert property (p_char) else $error("char clock pulse");
endmodule : eu_checker

bind extension_unlock_aperture_decode eu_checker i_eu_checker (.CLK, .NRST,
   .SEQ_INDEX, .SEQ_WR, .SEQ_RD, .SEQ_WDATA, .SEQ_RDATA, .SEQ_RHIT,
   .EXT_UNLOCKED, .CHAR_CLOCK_DIVIDER_FIELD, .MEM_REQ, .MEM_ADDR,
   .MEM_CLAIM, .MEM_OFFSET, .CHAIN4_256, .DOT_CLK_EN, .CHAR_CLK_EN);

// File: host_model.sv
// Host processor model driving the sequencer index and data port.
module host_model (
   // Clock
   input wire logic clk,
   // Sequencer port
   output logic [7:0] idx,
   output logic wr,
   output logic rd,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic rhit
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      idx = 8'hff;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 8'h00;
   end
   // Index and data are inverted once released so stale values never match.
   task automatic access(input logic [7:0] i, input logic [7:0] d,
      input logic r, output logic [7:0] q, output logic h);
      @(negedge clk);
      idx = i;
      wdata = d;
      wr = !r;
      rd = r;
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b0;
      idx = ~i;
      wdata = ~d;
      q = rdata;
      h = rhit;
   endtask : access
endmodule : host_model

// File: extension_unlock_aperture_decode_test.sv
// Self-checking bench for the extension unlock and aperture decode block.
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
   $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module extension_unlock_aperture_decode_test;
   timeunit 1ns;
   timeprecision 1ps;
   import ext_seq_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, mreq = 1'b0, two_mb = 1'b0, nine = 1'b0;
   logic dot = 1'b0, ccen, claim, unl, hires, wr, rd, rhit;
   logic [7:0] idx, wdata, rdata;
   logic [31:0] maddr = 32'h0;
   logic [21:0] moff, moff_p;
   logic dec = 1'b0, chain4 = 1'b0, claim_p, claim_l;
   logic [2:0] field;
   logic [7:0] bad[3] = '{8'h13, 8'h02, 8'h1e};
   int per[5] = '{8, 16, 24, 8, 8};
   int fails = 0, tests_run = 0;
   always #2 clk = ~clk;
   host_model i_host_model (.clk(clk), .idx(idx), .wr(wr), .rd(rd),
      .wdata(wdata), .rdata(rdata), .rhit(rhit));
   extension_unlock_aperture_decode i_extension_unlock_aperture_decode (
      .CLK(clk), .NRST(nrst), .SEQ_INDEX(idx), .SEQ_WR(wr), .SEQ_RD(rd),
      .SEQ_WDATA(wdata), .SEQ_RDATA(rdata), .SEQ_RHIT(rhit), .MEM_REQ(mreq),
      .MEM_ADDR(maddr), .HIGH_MEMORY_DECODE_INPUT(1'b0),
      .LOW_MEMORY_DECODE_INPUT(1'b0), .PCI_BASE(8'h00),
      .LEGACY_MAP_SEL(2'b00), .TWO_MEGABYTE_WINDOW_BIT(two_mb),
      .CHAIN4_256(chain4), .NINE_DOT_CHARS(nine), .DOT_CLK_EN(dot),
      .CHAR_CLK_EN(ccen), .MEM_CLAIM(claim), .MEM_OFFSET(moff),
      .SWAP_APERTURE(), .EXT_UNLOCKED(unl),
      .CHAR_CLOCK_DIVIDER_FIELD(field), .HIGH_RES_PACKED(hires));
   // PCI and local-bus variants share the port writes of the main instance.
   if (1) begin : g_pci
      extension_unlock_aperture_decode #(.BUS(BUS_PCI))
         i_extension_unlock_aperture_decode (
         .CLK(clk), .NRST(nrst), .SEQ_INDEX(idx), .SEQ_WR(wr), .SEQ_RD(rd),
         .SEQ_WDATA(wdata), .SEQ_RDATA(), .SEQ_RHIT(), .MEM_REQ(mreq),
         .MEM_ADDR(maddr), .HIGH_MEMORY_DECODE_INPUT(1'b0),
         .LOW_MEMORY_DECODE_INPUT(1'b0), .PCI_BASE(8'hd0),
         .LEGACY_MAP_SEL(2'b00), .TWO_MEGABYTE_WINDOW_BIT(1'b0),
         .CHAIN4_256(1'b0), .NINE_DOT_CHARS(1'b0), .DOT_CLK_EN(dot),
         .CHAR_CLK_EN(), .MEM_CLAIM(claim_p), .MEM_OFFSET(moff_p),
         .SWAP_APERTURE(), .EXT_UNLOCKED(), .CHAR_CLOCK_DIVIDER_FIELD(),
         .HIGH_RES_PACKED());
   end
   if (1) begin : g_local
      extension_unlock_aperture_decode #(.BUS(BUS_LOCAL))
         i_extension_unlock_aperture_decode (
         .CLK(clk), .NRST(nrst), .SEQ_INDEX(idx), .SEQ_WR(wr), .SEQ_RD(rd),
         .SEQ_WDATA(wdata), .SEQ_RDATA(), .SEQ_RHIT(), .MEM_REQ(mreq),
         .MEM_ADDR(maddr), .HIGH_MEMORY_DECODE_INPUT(dec),
         .LOW_MEMORY_DECODE_INPUT(dec), .PCI_BASE(8'h00),
         .LEGACY_MAP_SEL(2'b00), .TWO_MEGABYTE_WINDOW_BIT(1'b0),
         .CHAIN4_256(1'b0), .NINE_DOT_CHARS(1'b0), .DOT_CLK_EN(dot),
         .CHAR_CLK_EN(), .MEM_CLAIM(claim_l), .MEM_OFFSET(),
         .SWAP_APERTURE(), .EXT_UNLOCKED(), .CHAR_CLOCK_DIVIDER_FIELD(),
         .HIGH_RES_PACKED());
   end
   task automatic print_verdict;
      $display("checks run %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   task automatic rdchk(input logic [7:0] i, input logic [7:0] e,
      input logic eh);
      logic [7:0] q;
      logic h;
      i_host_model.access(i, 8'h00, 1'b1, q, h);
      `CHK("rdata", e, q)
      `CHK("rhit", eh, h)
   endtask : rdchk
   task automatic wrt(input logic [7:0] i, input logic [7:0] d);
      logic [7:0] q;
      logic h;
      i_host_model.access(i, d, 1'b0, q, h);
   endtask : wrt
   task automatic mem(input logic [31:0] a, input logic ec,
      input logic [21:0] eo);
      @(negedge clk);
      mreq = 1'b1;
      maddr = a;
      @(negedge clk);
      mreq = 1'b0;
      maddr = ~a;
      `CHK("claim", ec, claim)
      if (ec && a[31:20] != 12'h000) `CHK("offset", eo, moff)
   endtask : mem
   task automatic mem_ext(input logic [31:0] a, input logic ep,
      input logic el, input logic [21:0] eo);
      @(negedge clk);
      mreq = 1'b1;
      maddr = a;
      @(negedge clk);
      mreq = 1'b0;
      maddr = ~a;
      `CHK("pci claim", ep, claim_p)
      `CHK("local claim", el, claim_l)
      if (ep) `CHK("pci offset", eo, moff_p)
   endtask : mem_ext
   // The first pulse may close a period begun under the old mode.
   task automatic period(input int n);
      int k;
      for (k = 0; k < 60 && ccen !== 1'b1; k++) @(negedge clk);
      if (k == 60) begin
         fails++;
         print_verdict();
      end
      @(negedge clk);
      for (k = 1; k < 60 && ccen !== 1'b1; k++) @(negedge clk);
      `CHK("char period", n, k)
      if (k == 60) print_verdict();
   endtask : period
   initial begin
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      rdchk(8'h06, 8'h0f, 1'b1);
      `CHK("unlocked", 1'b0, unl)
      rdchk(8'h07, 8'h00, 1'b0);
      wrt(8'h07, 8'h35);
      wrt(8'h06, 8'hfa);
      rdchk(8'h06, 8'h12, 1'b1);
      `CHK("unlocked", 1'b1, unl)
      rdchk(8'h07, 8'h00, 1'b1);
      foreach (bad[j]) begin
         wrt(8'h06, bad[j]);
         rdchk(8'h06, 8'h0f, 1'b1);
         `CHK("unlocked", 1'b0, unl)
      end
      wrt(8'h06, 8'h12);
      dot = 1'b1;
      for (int c = 0; c < 5; c++) begin
         wrt(8'h07, {4'h3, c[2:0], 1'b0});
         @(negedge clk);
         `CHK("divider", c[2:0], field)
         period(per[c]);
      end
      wrt(8'h07, 8'h30);
      nine = 1'b1;
      period(9);
      wrt(8'h07, 8'h31);
      @(negedge clk);
      `CHK("packed", 1'b1, hires)
      period(8);
      // Decode pins pass two flops, so settle them before the request.
      dec = 1'b1;
      repeat (3) @(negedge clk);
      mem_ext(32'hd0312345, 1'b1, 1'b1, 22'h012345);
      mem_ext(32'hd0412345, 1'b0, 1'b1, 22'h000000);
      dec = 1'b0;
      repeat (3) @(negedge clk);
      mem_ext(32'hd0312345, 1'b1, 1'b0, 22'h012345);
      mem(32'h00312345, 1'b1, 22'h012345);
      mem(32'h00212345, 1'b0, 22'h000000);
      two_mb = 1'b1;
      mem(32'h00212345, 1'b1, 22'h012345);
      chain4 = 1'b1;
      mem(32'h00312345, 1'b1, 22'h112345);
      chain4 = 1'b0;
      wrt(8'h07, 8'h00);
      mem(32'h00312345, 1'b0, 22'h000000);
      mem(32'h000a1234, 1'b1, 22'h000000);
      mem(32'h000c1234, 1'b0, 22'h000000);
      print_verdict();
   end
endmodule : extension_unlock_aperture_decode_test
